// File: src/sfx_pkg.sv
// constants and types shared by the simd floating-point exception unit
package sfx_pkg;

	// lanes of a packed operation
	localparam int SFX_LANES = 4;

	// register offsets (byte addresses)
	localparam logic [7:0] SFX_ADDR_CSR = 8'h00;
	localparam logic [7:0] SFX_ADDR_OSS = 8'h04;

	// control/status field positions
	localparam int SFX_B_IE         = 0;
	localparam int SFX_B_SUBN_FLG   = 1;
	localparam int SFX_B_DIVNIL_FLG = 2;
	localparam int SFX_B_OE         = 3;
	localparam int SFX_B_UFL_FLG    = 4;
	localparam int SFX_B_INEX_FLG   = 5;
	localparam int SFX_B_SUBN_NIL   = 6;
	localparam int SFX_B_IM         = 7;
	localparam int SFX_B_SUBN_MSK   = 8;
	localparam int SFX_B_DIVNIL_MSK = 9;
	localparam int SFX_B_OVF_MSK    = 10;
	localparam int SFX_B_UFL_MSK    = 11;
	localparam int SFX_B_INEX_MSK   = 12;
	localparam int SFX_B_FTZ        = 15;

	// os support register field
	localparam int SFX_B_OSS = 10;

	// reset values and writable bits
	localparam logic [15:0] SFX_CSR_RST   = 16'h1F80;
	localparam logic [15:0] SFX_CSR_WMASK = 16'h9FFF;
	localparam logic        SFX_OSS_RST   = 1'b0;

	// conditions known before the computation, one lane
	typedef struct packed {
		logic invalid;
		logic src_subnormal;
		logic div_op;
		logic dividend_ok;
		logic divisor_zero;
	} sfx_pre_s;

	// conditions known after rounding, one lane
	typedef struct packed {
		logic overflow;
		logic tiny;
		logic inexact;
	} sfx_post_s;

	typedef enum logic [1:0] {
		S_IDLE,
		S_PRE_WAIT,
		S_POST,
		S_POST_WAIT
	} sfx_state_e;

	// whole state of the unit
	typedef struct packed {
		sfx_state_e             st;
		logic [15:0]            csr;
		logic                   oss;
		logic [31:0]            rdata;
		logic                   fault;
		logic                   fault_ud;
		logic                   fault_post;
		logic                   done;
		logic [SFX_LANES-1:0]   flush;
		logic [SFX_LANES-1:0]   src_nil;
	} sfx_state_s;

endpackage

// File: src/sfx_simd_fp_exception_unit.sv
// simd floating-point exception unit: detection, sticky flags, fault sequencing
`timescale 1ns/1ps
module sfx_simd_fp_exception_unit
	import sfx_pkg::*;
(
	// clock and reset
	input  wire logic                        CLK_SYS_I,
	input  wire logic                        RST_B_I,
	// register port
	input  wire logic [7:0]                  REG_ADDR_I,
	input  wire logic [31:0]                 REG_WDATA_I,
	input  wire logic                        REG_WR_I,
	input  wire logic                        REG_RD_I,
	output logic      [31:0]                 REG_RDATA_O,
	// instruction request
	input  wire logic                        OP_VALID_I,
	output logic                             OP_READY_O,
	input  wire sfx_pre_s  [SFX_LANES-1:0]   OP_PRE_I,
	input  wire sfx_post_s [SFX_LANES-1:0]   OP_POST_I,
	output logic                             POST_SAMPLE_O,
	// fault handling
	input  wire logic                        HANDLER_RET_I,
	output logic                             FAULT_O,
	output logic                             FAULT_UD_O,
	output logic                             FAULT_POST_O,
	// completion and lane controls
	output logic                             DONE_O,
	output logic      [SFX_LANES-1:0]        FLUSH_LANES_O,
	output logic      [SFX_LANES-1:0]        SRC_NIL_O,
	output logic                             BUSY_O
);

	function automatic logic any_lane(input logic [SFX_LANES-1:0] v);
		any_lane = |v;
	endfunction

	sfx_state_s q;
	sfx_state_s d;

	logic [SFX_LANES-1:0] lane_ie;
	logic [SFX_LANES-1:0] lane_subn;
	logic [SFX_LANES-1:0] lane_dz;
	logic [SFX_LANES-1:0] lane_nil;
	logic [SFX_LANES-1:0] lane_oe;
	logic [SFX_LANES-1:0] lane_tiny;
	logic [SFX_LANES-1:0] lane_flush;
	logic [SFX_LANES-1:0] lane_inex;
	logic [SFX_LANES-1:0] lane_ufl;

	logic        subn_nil;
	logic        ftz;
	logic        ufl_msk;
	logic        take;
	logic        post_smp;
	logic        pre_unm;
	logic        post_unm;
	logic        wr_csr;
	logic        wr_oss;
	logic [5:0]  pre_set;
	logic [5:0]  post_set;

	assign subn_nil = q.csr[SFX_B_SUBN_NIL];
	assign ftz      = q.csr[SFX_B_FTZ];
	assign ufl_msk  = q.csr[SFX_B_UFL_MSK];

	// per-lane condition detection
	for (genvar g = 0; g < SFX_LANES; g++) begin : g_lane
		assign lane_ie[g]    = OP_PRE_I[g].invalid;
		// subnormal sources read as zero under the nil setting, so no subnormal condition
		assign lane_subn[g]  = OP_PRE_I[g].src_subnormal & ~subn_nil;
		assign lane_nil[g]   = OP_PRE_I[g].src_subnormal & subn_nil;
		// raw operand classes only: neither mode bit takes part
		assign lane_dz[g]    = OP_PRE_I[g].div_op & OP_PRE_I[g].dividend_ok & OP_PRE_I[g].divisor_zero;
		assign lane_oe[g]    = OP_POST_I[g].overflow;
		assign lane_tiny[g]  = OP_POST_I[g].tiny;
		assign lane_flush[g] = OP_POST_I[g].tiny & ftz & ufl_msk;
		// a flushed result is never exact
		assign lane_inex[g]  = OP_POST_I[g].inexact | lane_flush[g];
		assign lane_ufl[g]   = ufl_msk ? (lane_tiny[g] & lane_inex[g]) : lane_tiny[g];
	end

	// lane conditions ORed into flag-set vectors
	always_comb begin
		pre_set = 6'h00;
		pre_set[SFX_B_IE] = any_lane(lane_ie);
		pre_set[SFX_B_SUBN_FLG] = any_lane(lane_subn);
		pre_set[SFX_B_DIVNIL_FLG] = any_lane(lane_dz);
		post_set = 6'h00;
		post_set[SFX_B_OE] = any_lane(lane_oe);
		post_set[SFX_B_UFL_FLG] = any_lane(lane_ufl);
		post_set[SFX_B_INEX_FLG] = any_lane(lane_inex);
	end

	assign pre_unm = (pre_set[SFX_B_IE] & ~q.csr[SFX_B_IM])
		| (pre_set[SFX_B_SUBN_FLG] & ~q.csr[SFX_B_SUBN_MSK])
		| (pre_set[SFX_B_DIVNIL_FLG] & ~q.csr[SFX_B_DIVNIL_MSK]);
	assign post_unm = (post_set[SFX_B_OE] & ~q.csr[SFX_B_OVF_MSK])
		| (any_lane(lane_tiny) & ~ufl_msk)
		| (post_set[SFX_B_INEX_FLG] & ~q.csr[SFX_B_INEX_MSK]);

	assign take     = OP_VALID_I & (q.st == S_IDLE);
	assign post_smp = (q.st == S_POST);
	assign wr_csr   = REG_WR_I & (REG_ADDR_I == SFX_ADDR_CSR);
	assign wr_oss   = REG_WR_I & (REG_ADDR_I == SFX_ADDR_OSS);

	always_comb begin
		d       = q;
		d.fault = 1'b0;
		d.done  = 1'b0;
		d.rdata = 32'h0000_0000;

		// register reads answer one cycle later; unmapped reads return zero
		if (REG_RD_I) begin
			if (REG_ADDR_I == SFX_ADDR_CSR) begin
				d.rdata[15:0] = q.csr;
			end else if (REG_ADDR_I == SFX_ADDR_OSS) begin
				d.rdata[SFX_B_OSS] = q.oss;
			end
		end
		if (wr_csr) begin
			d.csr = REG_WDATA_I[15:0] & SFX_CSR_WMASK;
		end
		if (wr_oss) begin
			d.oss = REG_WDATA_I[SFX_B_OSS];
		end

		case (q.st)
			S_IDLE: begin
				if (take) begin
					// pre-computation phase comes first
					d.csr[5:0] = d.csr[5:0] | pre_set;
					d.src_nil  = lane_nil;
					if (pre_unm) begin
						d.fault      = 1'b1;
						d.fault_ud   = ~q.oss;
						d.fault_post = 1'b0;
						d.st         = S_PRE_WAIT;
					end else begin
						d.st = S_POST;
					end
				end
			end
			S_PRE_WAIT: begin
				if (HANDLER_RET_I) begin
					d.st = S_POST;
				end
			end
			S_POST: begin
				d.csr[5:0] = d.csr[5:0] | post_set;
				d.flush    = lane_flush;
				if (post_unm) begin
					d.fault      = 1'b1;
					d.fault_ud   = ~q.oss;
					d.fault_post = 1'b1;
					d.st         = S_POST_WAIT;
				end else begin
					d.done = 1'b1;
					d.st   = S_IDLE;
				end
			end
			S_POST_WAIT: begin
				if (HANDLER_RET_I) begin
					d.done = 1'b1;
					d.st   = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_B_I) begin
			q.st         <= S_IDLE;
			q.csr        <= SFX_CSR_RST;
			q.oss        <= SFX_OSS_RST;
			q.rdata      <= 32'h0000_0000;
			q.fault      <= 1'b0;
			q.fault_ud   <= 1'b0;
			q.fault_post <= 1'b0;
			q.done       <= 1'b0;
			q.flush      <= '0;
			q.src_nil    <= '0;
		end else begin
			q <= d;
		end
	end

	assign REG_RDATA_O   = q.rdata;
	assign OP_READY_O    = (q.st == S_IDLE);
	assign POST_SAMPLE_O = post_smp;
	assign FAULT_O       = q.fault;
	assign FAULT_UD_O    = q.fault_ud;
	assign FAULT_POST_O  = q.fault_post;
	assign DONE_O        = q.done;
	assign FLUSH_LANES_O = q.flush;
	assign SRC_NIL_O     = q.src_nil;
	assign BUSY_O        = (q.st != S_IDLE);

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);

	sequence s_pre_fault;
		take && pre_unm;
	endsequence

	sequence s_post_fault;
		post_smp && post_unm;
	endsequence

	// masked pre phase goes straight on to the post check
	sequence s_pre_masked;
		take && !pre_unm;
	endsequence

	// post check with a rounded result beyond the largest finite value
	sequence s_post_ovf;
		post_smp && any_lane(lane_oe);
	endsequence

	// masked underflow that also lost precision
	sequence s_post_tiny_inex;
		post_smp && ufl_msk && any_lane(lane_tiny & lane_inex);
	endsequence

	// handler returns in each wait state
	sequence s_pre_returned;
		q.st == S_PRE_WAIT && HANDLER_RET_I;
	endsequence

	sequence s_post_returned;
		q.st == S_POST_WAIT && HANDLER_RET_I;
	endsequence

	a_pre_fault_path: assert property (s_pre_fault |=> FAULT_O && !FAULT_POST_O && !DONE_O ##1 !FAULT_O)
		else $error("pre fault not raised");

	a_post_fault_path: assert property (s_post_fault |=> FAULT_O && FAULT_POST_O && !DONE_O)
		else $error("post fault not raised");

	a_fault_kind_os: assert property ((take || post_smp) && !wr_oss |=> !FAULT_O || (FAULT_UD_O == !q.oss))
		else $error("wrong fault kind");

	a_divzero_flag: assert property (take && any_lane(lane_dz) |=> q.csr[SFX_B_DIVNIL_FLG])
		else $error("divide by nil flag missing");

	a_divzero_modes: assert property (take && any_lane(lane_dz) && (ftz || subn_nil)
		|=> q.csr[SFX_B_DIVNIL_FLG])
		else $error("divide by nil lost under a mode bit");

	a_divzero_fault: assert property (take && any_lane(lane_dz) && !q.csr[SFX_B_DIVNIL_MSK]
		|=> FAULT_O && !FAULT_POST_O)
		else $error("unmasked divide by nil did not fault");

	a_subnormal_flag: assert property (take && any_lane(lane_subn) |=> q.csr[SFX_B_SUBN_FLG])
		else $error("subnormal flag missing");

	a_subnormal_fault: assert property (take && any_lane(lane_subn) && !q.csr[SFX_B_SUBN_MSK]
		|=> FAULT_O && !FAULT_POST_O)
		else $error("unmasked subnormal input did not fault");

	a_nil_suppress: assert property (take && subn_nil && !wr_csr && !q.csr[SFX_B_SUBN_FLG]
		|=> !q.csr[SFX_B_SUBN_FLG])
		else $error("subnormal flag set while sources read as nil");

	a_nil_lanes_off: assert property (take && !subn_nil |=> SRC_NIL_O == '0)
		else $error("source lanes zeroed without the nil setting");

	a_overflow_flag: assert property (s_post_ovf |=> q.csr[SFX_B_OE])
		else $error("overflow flag missing");

	a_overflow_modes: assert property (post_smp && any_lane(lane_oe) && (ftz || subn_nil)
		|=> q.csr[SFX_B_OE])
		else $error("overflow lost under a mode bit");

	a_overflow_fault: assert property (post_smp && any_lane(lane_oe) && !q.csr[SFX_B_OVF_MSK]
		|=> FAULT_O && FAULT_POST_O)
		else $error("unmasked overflow did not fault");

	a_ufl_unmasked: assert property (post_smp && !ufl_msk && any_lane(lane_tiny)
		|=> FAULT_O && q.csr[SFX_B_UFL_FLG])
		else $error("unmasked tiny result not reported");

	a_ufl_masked_set: assert property (s_post_tiny_inex |=> q.csr[SFX_B_UFL_FLG])
		else $error("masked tiny inexact result not flagged");

	a_inexact_flag: assert property (post_smp && any_lane(lane_inex) |=> q.csr[SFX_B_INEX_FLG])
		else $error("inexact flag missing");

	a_inexact_flush: assert property (post_smp && any_lane(lane_flush)
		|=> q.csr[SFX_B_INEX_FLG] && q.csr[SFX_B_UFL_FLG])
		else $error("flush lost inexact");

	a_flush_gated: assert property (post_smp && !(ftz && ufl_msk) |=> FLUSH_LANES_O == '0)
		else $error("lanes flushed without masked flush-to-zero");

	a_ufl_masked_clear: assert property (post_smp && ufl_msk && !any_lane(lane_ufl) && !q.csr[SFX_B_UFL_FLG]
		&& !wr_csr |=> !q.csr[SFX_B_UFL_FLG])
		else $error("underflow flag set without inexact");

	// flags only fall by a software write or a reset
	a_flags_sticky: assert property (!wr_csr |=> (q.csr[5:0] & $past(q.csr[5:0])) == $past(q.csr[5:0]))
		else $error("sticky flag lost");

	a_mixed_flags: assert property (s_post_tiny_inex and post_unm
		|=> FAULT_O && q.csr[SFX_B_UFL_FLG])
		else $error("masked flag missing beside unmasked fault");

	a_pre_masked_on: assert property (s_pre_masked |=> POST_SAMPLE_O && !FAULT_O)
		else $error("masked pre condition stalled");

	a_fault_pulse: assert property (FAULT_O |=> !FAULT_O)
		else $error("fault longer than one cycle");

	a_done_pulse: assert property (DONE_O |=> !DONE_O)
		else $error("completion longer than one cycle");
	a_masked_commit: assert property (post_smp && !post_unm |=> DONE_O && !FAULT_O && FLUSH_LANES_O == $past(lane_flush))
		else $error("masked result not committed");
	a_withhold_result: assert property (q.st == S_POST_WAIT && !HANDLER_RET_I |=> !DONE_O && q.st == S_POST_WAIT)
		else $error("result released early");
	a_post_return_done: assert property (s_post_returned |=> DONE_O ##1 !DONE_O)
		else $error("no completion after post return");

	a_pre_then_post: assert property (s_pre_returned |=> POST_SAMPLE_O)
		else $error("post check skipped");

endmodule

// File: verif/tb_top.sv
// self-checking bench for the simd floating-point exception unit
`timescale 1ns/1ps
module tb_top
	import sfx_pkg::*;
;
	typedef struct packed {
		logic [15:0] ctl;
		logic [19:0] pre;
		logic [11:0] post;
		logic [15:0] csr;
		logic [3:0]  fl;
		logic [3:0]  nl;
	} sfx_row_s;

	logic                          clk = 1'b0;
	logic                          rst_b;
	logic [7:0]                    addr;
	logic [31:0]                   wdata;
	logic                          wr;
	logic                          rd;
	logic [31:0]                   rdata;
	logic                          op_valid;
	logic                          ready;
	sfx_pre_s  [SFX_LANES-1:0]     pre;
	sfx_post_s [SFX_LANES-1:0]     post;
	logic                          post_smp;
	logic                          ret;
	logic                          fault;
	logic                          fault_ud;
	logic                          fault_post;
	logic                          done;
	logic [SFX_LANES-1:0]          flush;
	logic [SFX_LANES-1:0]          nil;
	logic                          busy;
	int                            failures = 0;
	int                            n_checks = 0;
	int                            cycles = 0;
	// control word, lane inputs, expected csr, flushed lanes, nil-source lanes
	sfx_row_s                      rows [11] = '{
		'{16'h1F80, 20'h0_0007, 12'h000, 16'h1F84, 4'h0, 4'h0},
		'{16'h9FC0, 20'h0_1C00, 12'h000, 16'h9FC4, 4'h0, 4'h0},
		'{16'h1F80, 20'h0_0005, 12'h000, 16'h1F80, 4'h0, 4'h0},
		'{16'h9FC0, 20'h0_0000, 12'h800, 16'h9FC8, 4'h0, 4'h0},
		'{16'h1F80, 20'h0_0000, 12'h018, 16'h1FB0, 4'h0, 4'h0},
		'{16'h1F80, 20'h0_0000, 12'h002, 16'h1F80, 4'h0, 4'h0},
		'{16'h9F80, 20'h0_0000, 12'h002, 16'h9FB0, 4'h1, 4'h0},
		'{16'h1FC0, 20'h0_0000, 12'h040, 16'h1FE0, 4'h0, 4'h0},
		'{16'h1F80, 20'h4_0008, 12'h000, 16'h1F82, 4'h0, 4'h0},
		'{16'h1FC0, 20'h4_0008, 12'h000, 16'h1FC0, 4'h0, 4'h9},
		'{16'h1F80, 20'h0_0008, 12'h700, 16'h1FBA, 4'h0, 4'h0}
	};

	sfx_simd_fp_exception_unit i_sfx_simd_fp_exception_unit (
		.CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .OP_VALID_I(op_valid), .OP_READY_O(ready), .OP_PRE_I(pre),
		.OP_POST_I(post), .POST_SAMPLE_O(post_smp), .HANDLER_RET_I(ret), .FAULT_O(fault),
		.FAULT_UD_O(fault_ud), .FAULT_POST_O(fault_post), .DONE_O(done), .FLUSH_LANES_O(flush),
		.SRC_NIL_O(nil), .BUSY_O(busy)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// ends 1 ns into the cycle after the accept edge
	task automatic start_op(input logic [19:0] p, input logic [11:0] q);
		@(posedge clk);
		op_valid <= 1'b1;
		pre <= p;
		post <= q;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic ret_h();
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		#1;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		rst_b = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
		op_valid = 1'b0; pre = '0; post = '0; ret = 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_chk(SFX_ADDR_CSR, 32'h0000_1F80);
		rd_chk(8'h08, 32'h0);
		wr_reg(SFX_ADDR_CSR, 32'hFFFF_FFFF);
		rd_chk(SFX_ADDR_CSR, 32'h0000_9FFF);
		rd_chk(SFX_ADDR_OSS, 32'h0);
		$display("test reset_regs done");
		foreach (rows[i]) begin
			wr_reg(SFX_ADDR_CSR, {16'h0, rows[i].ctl});
			start_op(rows[i].pre, rows[i].post);
			chk(32'(post_smp), 32'h1);
			@(posedge clk);
			#1 chk(32'(done), 32'h1);
			chk(32'(flush), 32'(rows[i].fl));
			chk(32'(nil), 32'(rows[i].nl));
			rd_chk(SFX_ADDR_CSR, {16'h0, rows[i].csr});
		end
		$display("test masked_rows done");
		// unmasked divide-by-zero with os support clear
		wr_reg(SFX_ADDR_CSR, 32'h0000_1D80);
		start_op(20'h0_0007, 12'h004);
		chk(32'({fault, fault_ud, fault_post, post_smp}), 32'hC);
		chk(32'({busy, ready}), 32'h2);
		rd_chk(SFX_ADDR_CSR, 32'h0000_1D84);
		ret_h();
		chk(32'(post_smp), 32'h1);
		@(posedge clk);
		#1 chk(32'(done), 32'h1);
		rd_chk(SFX_ADDR_CSR, 32'h0000_1D8C);
		$display("test pre_fault done");
		// two faults in one instruction, masked underflow still flagged
		wr_reg(SFX_ADDR_OSS, 32'h0000_0400);
		wr_reg(SFX_ADDR_CSR, 32'h0000_1980);
		start_op(20'h0_0007, 12'h01C);
		chk(32'({fault, fault_ud, fault_post}), 32'h4);
		ret_h();
		@(posedge clk);
		#1 chk(32'({fault, fault_post, done}), 32'h6);
		rd_chk(SFX_ADDR_CSR, 32'h0000_19BC);
		ret_h();
		chk(32'(done), 32'h1);
		$display("test two_faults done");
		// reset in mid-run restores defaults
		wr_reg(SFX_ADDR_CSR, 32'h0000_9FFF);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_chk(SFX_ADDR_CSR, 32'h0000_1F80);
		rd_chk(SFX_ADDR_OSS, 32'h0);
		$display("test mid_reset done");
		test_done();
	end
endmodule
